// File: design/vpg_prim_id_gen.sv
module vpg_prim_id_gen
  import vpg_pkg::*;
#(
  parameter int PEND_DEPTH = 6
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic              in_valid,
  input  wire vpg_vin_s          in_data,
  output logic                   in_ready,
  input  wire logic              cmd_valid,
  input  wire logic [31:0]       cmd_dword,
  output logic                   st_valid,
  output vpg_stw_s               st_wr,
  output logic                   out_valid,
  output vpg_vtx_s               out_vtx,
  input  wire logic              out_ready,
  output logic                   rel_valid,
  output logic [HANDLE_W-1:0]    rel_handle,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  generate
    if (PEND_DEPTH < 6 || PEND_DEPTH > 7)
    begin : g_chk
      $error("PEND_DEPTH must be 6 or 7");
    end
  endgenerate

  typedef enum logic [1:0] {F_IDLE, F_DRAIN, F_DROP, F_FLUSH} vpg_fst_e;

  function automatic logic vpg_mapped(input logic [AXI_AW-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_VTX
        || a == REG_OBJ || a == REG_SEQ;
  endfunction : vpg_mapped

  // ----------------------------------------------------------------
  // Generator state
  // ----------------------------------------------------------------
  logic                  in_ready_r;
  logic [2:0]            s_cnt_r;
  logic [2:0]            r_cnt_r;
  logic [SEQ_W-1:0]      seq_r;
  logic                  start_next_r;
  logic                  hold_v_r;
  vpg_vtx_s              hold_r;
  logic                  gq_v_r;
  vpg_vtx_s              gq_r;
  logic                  flush_r;
  logic                  st_valid_r;
  vpg_stw_s              st_wr_r;
  logic                  draw_act_r;
  logic                  dstat_r;
  logic                  stats_en_r;
  logic                  tally_clr_r;
  logic [CNT_W-1:0]      vtx_tally_r;
  logic [CNT_W-1:0]      obj_tally_r;

  // Filter state
  vpg_fst_e              fst_r;
  vpg_vtx_s              pend_r [PEND_DEPTH];
  logic [2:0]            pcnt_r;
  logic [2:0]            rd_r;
  logic [2:0]            nv_r;
  logic [2:0]            ph_r;
  logic                  fend_r;
  logic                  oh_v_r;
  vpg_vtx_s              oh_r;
  logic                  out_valid_r;
  vpg_vtx_s              out_r;
  logic                  rel_valid_r;
  logic [HANDLE_W-1:0]   rel_handle_r;

  // ----------------------------------------------------------------
  // Generator next values
  // ----------------------------------------------------------------
  vpg_shape_s            shp;
  logic                  beat;
  logic                  term;
  logic [2:0]            s_b;
  logic [2:0]            r_b;
  logic [SEQ_W-1:0]      seq_b;
  logic [2:0]            s_nxt;
  logic [2:0]            r_nxt;
  logic [SEQ_W-1:0]      seq_nxt;
  logic                  flush_go;
  logic                  gq_push;
  logic                  gq_v_nxt;
  logic                  flush_nxt;
  logic                  flt_take;
  logic                  stat_on;

  always_comb
  begin
    shp      = vpg_shape(in_data.topo);
    beat     = ce && in_valid && in_ready_r;
    term     = in_data.cut || in_data.inst_first;
    s_b      = term ? 3'd0 : s_cnt_r;
    r_b      = term ? 3'd0 : r_cnt_r;
    seq_b    = in_data.inst_first ? '0 : seq_r;
    s_nxt    = s_b;
    r_nxt    = r_b;
    seq_nxt  = seq_b;
    if (!in_data.cut)
    begin
      if (s_b < shp.s)
        s_nxt = s_b + 3'd1;
      else if (r_b < shp.r)
        r_nxt = r_b + 3'd1;
      else
      begin
        seq_nxt = seq_b + 1'b1;
        r_nxt   = 3'd0;
      end
    end
    flush_go  = ce && flush_r && !gq_v_r;
    gq_push   = hold_v_r && (beat || flush_go);
    gq_v_nxt  = gq_push || (gq_v_r && !flt_take);
    flush_nxt = beat ? in_data.draw_last : (flush_r && !flush_go);
    stat_on   = draw_act_r ? dstat_r : stats_en_r;
  end

  // ----------------------------------------------------------------
  // Vertex generator with one held vertex
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      in_ready_r   <= 1'b0;
      s_cnt_r      <= 3'd0;
      r_cnt_r      <= 3'd0;
      seq_r        <= '0;
      start_next_r <= 1'b1;
      hold_v_r     <= 1'b0;
      hold_r       <= '0;
      gq_v_r       <= 1'b0;
      gq_r         <= '0;
      flush_r      <= 1'b0;
      st_valid_r   <= 1'b0;
      st_wr_r      <= '0;
      draw_act_r   <= 1'b0;
      dstat_r      <= 1'b0;
    end
    else if (ce)
    begin
      in_ready_r <= !gq_v_nxt && !flush_nxt;
      flush_r    <= flush_nxt;
      st_valid_r <= 1'b0;
      if (flt_take)
        gq_v_r <= 1'b0;
      if (gq_push)
      begin
        gq_r          <= hold_r;
        gq_r.prim_end <= flush_go || term;
        gq_v_r        <= 1'b1;
      end
      if (beat)
      begin
        s_cnt_r    <= s_nxt;
        r_cnt_r    <= r_nxt;
        seq_r      <= seq_nxt;
        draw_act_r <= !in_data.draw_last;
        if (!draw_act_r)
          dstat_r <= stats_en_r;
        if (in_data.cut)
        begin
          hold_v_r     <= 1'b0;
          start_next_r <= 1'b1;
        end
        else
        begin
          hold_v_r          <= 1'b1;
          hold_r.prim_start <= in_data.inst_first || start_next_r;
          hold_r.prim_end   <= 1'b0;
          hold_r.topo       <= in_data.topo;
          hold_r.handle     <= in_data.handle;
          hold_r.seq        <= seq_nxt;
          start_next_r      <= 1'b0;
          st_valid_r        <= 1'b1;
          st_wr_r.handle    <= in_data.handle;
          st_wr_r.dst_off   <= in_data.dst_off;
          st_wr_r.comp_sel  <= in_data.comp_sel;
          st_wr_r.comp      <= in_data.comp;
        end
      end
      else if (flush_go)
      begin
        hold_v_r     <= 1'b0;
        start_next_r <= 1'b1;
        s_cnt_r      <= 3'd0;
        r_cnt_r      <= 3'd0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dangling-vertex filter
  // ----------------------------------------------------------------
  vpg_shape_s            fshp;
  logic [2:0]            nv_b;
  logic [2:0]            ph_b;
  logic [2:0]            nv1;
  logic                  complete;
  logic                  out_free;
  logic                  can_push;
  logic                  obj_cnt;

  always_comb
  begin
    fshp     = vpg_shape(gq_r.topo);
    flt_take = ce && gq_v_r && fst_r == F_IDLE;
    nv_b     = gq_r.prim_start ? 3'd0 : nv_r;
    ph_b     = gq_r.prim_start ? 3'd0 : ph_r;
    nv1      = nv_b + 3'd1;
    complete = nv1 >= fshp.min
            && (nv1 == fshp.min || ph_b + 3'd1 == fshp.step);
    out_free = !out_valid_r || out_ready;
    can_push = !oh_v_r || out_free;
    obj_cnt  = flt_take && complete && stat_on
            && !(gq_r.topo == TOPO_LINE_LOOP && gq_r.prim_end);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fst_r        <= F_IDLE;
      pcnt_r       <= 3'd0;
      rd_r         <= 3'd0;
      nv_r         <= 3'd0;
      ph_r         <= 3'd0;
      fend_r       <= 1'b0;
      oh_v_r       <= 1'b0;
      oh_r         <= '0;
      out_valid_r  <= 1'b0;
      out_r        <= '0;
      rel_valid_r  <= 1'b0;
      rel_handle_r <= '0;
      for (int i = 0; i < PEND_DEPTH; i++)
        pend_r[i] <= '0;
    end
    else if (ce)
    begin
      rel_valid_r <= 1'b0;
      if (out_valid_r && out_ready)
        out_valid_r <= 1'b0;
      case (fst_r)
        F_IDLE:
        begin
          if (flt_take)
          begin
            pend_r[pcnt_r] <= gq_r;
            pcnt_r         <= pcnt_r + 3'd1;
            nv_r           <= (nv1 >= fshp.min) ? fshp.min : nv1;
            ph_r           <= (complete || nv1 <= fshp.min) ? 3'd0 : ph_b + 3'd1;
            fend_r         <= gq_r.prim_end;
            rd_r           <= 3'd0;
            if (complete)
              fst_r <= F_DRAIN;
            else if (gq_r.prim_end)
              fst_r <= F_DROP;
          end
        end
        F_DRAIN:
        begin
          if (can_push)
          begin
            if (oh_v_r)
            begin
              out_r       <= oh_r;
              out_r.topo  <= vpg_entry_topo(oh_r.topo);
              out_valid_r <= 1'b1;
            end
            oh_r          <= pend_r[rd_r];
            oh_r.prim_end <= 1'b0;
            oh_v_r        <= 1'b1;
            rd_r          <= rd_r + 3'd1;
            if (rd_r + 3'd1 == pcnt_r)
            begin
              pcnt_r <= 3'd0;
              fst_r  <= fend_r ? F_FLUSH : F_IDLE;
            end
          end
        end
        F_DROP:
        begin
          rel_valid_r  <= 1'b1;
          rel_handle_r <= pend_r[rd_r].handle;
          rd_r         <= rd_r + 3'd1;
          if (rd_r + 3'd1 == pcnt_r)
          begin
            pcnt_r <= 3'd0;
            fst_r  <= F_FLUSH;
          end
        end
        default:
        begin
          if (!oh_v_r)
            fst_r <= F_IDLE;
          else if (out_free)
          begin
            out_r          <= oh_r;
            out_r.topo     <= vpg_entry_topo(oh_r.topo);
            out_r.prim_end <= 1'b1;
            out_valid_r    <= 1'b1;
            oh_v_r         <= 1'b0;
            fst_r          <= F_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Statistics control and tallies
  // ----------------------------------------------------------------
  logic                  cmd_hit;
  logic                  wr_hs;
  logic                  rd_hs;

  always_comb
  begin
    cmd_hit = cmd_valid
           && cmd_dword[31:29] == CMD_TYPE
           && (cmd_dword[28:27] == CMD_SUB_EARLY
               || cmd_dword[28:27] == CMD_SUB_LATE)
           && cmd_dword[26:24] == CMD_OP
           && cmd_dword[23:16] == CMD_SUBOP;
    wr_hs   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    rd_hs   = s_axi_arvalid && s_axi_arready;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stats_en_r  <= CTRL_EN_RST;
      tally_clr_r <= 1'b0;
    end
    else
    begin
      tally_clr_r <= 1'b0;
      if (ce && cmd_hit)
        stats_en_r <= cmd_dword[CMD_EN_BIT];
      else if (wr_hs && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0])
      begin
        stats_en_r  <= s_axi_wdata[CTRL_EN_BIT];
        tally_clr_r <= s_axi_wdata[CTRL_CLR_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vtx_tally_r <= '0;
      obj_tally_r <= '0;
    end
    else if (ce)
    begin
      if (beat && !in_data.cut && stat_on)
        vtx_tally_r <= (tally_clr_r ? '0 : vtx_tally_r) + 1'b1;
      else if (tally_clr_r)
        vtx_tally_r <= '0;
      if (obj_cnt)
        obj_tally_r <= (tally_clr_r ? '0 : obj_tally_r) + 1'b1;
      else if (tally_clr_r)
        obj_tally_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic                  awready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [1:0]            rresp_r;
  logic [31:0]           rdata_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
      if (wr_hs)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= vpg_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end
    else
    begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
      if (rd_hs)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= vpg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_araddr == REG_CTRL)
          rdata_r <= {31'h0, stats_en_r};
        else if (s_axi_araddr == REG_STATUS)
          rdata_r <= {24'h0, pcnt_r, fst_r, oh_v_r, hold_v_r, draw_act_r};
        else if (s_axi_araddr == REG_VTX)
          rdata_r <= vtx_tally_r;
        else if (s_axi_araddr == REG_OBJ)
          rdata_r <= obj_tally_r;
        else if (s_axi_araddr == REG_SEQ)
          rdata_r <= {{(32-SEQ_W){1'b0}}, seq_r};
        else
          rdata_r <= 32'h0;
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign in_ready      = in_ready_r;
  assign st_valid      = st_valid_r;
  assign st_wr         = st_wr_r;
  assign out_valid     = out_valid_r;
  assign out_vtx       = out_r;
  assign rel_valid     = rel_valid_r;
  assign rel_handle    = rel_handle_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = awready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

endmodule : vpg_prim_id_gen

// File: pkg/vpg_pkg.sv
//
// Functional notes
// - Start flag on instance or post-cut vertex
// - Object takes provoking vertex's sequence number
// - Skip, then repeat, then bump sequence
// - Skip counter cleared at primitive termination
// - Sequence number cleared at instance start
// - Point and line skip/repeat values
// - Triangle skip/repeat values
// - Quads use own values, become topology_a
// - Line loop uses 2,0, becomes strip
// - Components written from draw's write offset
// - One held vertex, released on next/termination
// - Drop short topologies and trailing vertices
// - Filter buffers, releases handles of dropped
// - Statistics command type and enable bit
// - Statistics command opcode fields
// - Count every fetched vertex while enabled
// - Count forwarded objects, not closing line
// - Disable freezes tallies for later draws
// - All-ones cut ends primitive, flushes held
// - Any delimiter clears skip and repeat
package vpg_pkg;

  localparam int HANDLE_W = 8;
  localparam int SEQ_W    = 16;
  localparam int CNT_W    = 32;
  localparam int COMP_W   = 32;

  // Statistics control command fields
  localparam logic [2:0] CMD_TYPE      = 3'h3;
  localparam logic [1:0] CMD_SUB_EARLY = 2'h3;
  localparam logic [1:0] CMD_SUB_LATE  = 2'h1;
  localparam logic [2:0] CMD_OP        = 3'h0;
  localparam logic [7:0] CMD_SUBOP     = 8'h0b;
  localparam int         CMD_EN_BIT    = 0;

  // Register map
  localparam int         AXI_AW      = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_VTX     = 8'h08;
  localparam logic [7:0] REG_OBJ     = 8'h0c;
  localparam logic [7:0] REG_SEQ     = 8'h10;
  localparam int         CTRL_EN_BIT = 0;
  localparam int         CTRL_CLR_BIT = 1;
  localparam logic       CTRL_EN_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    TOPO_POINT_LIST, TOPO_LINE_LIST, TOPO_LINE_LIST_ADJ, TOPO_LINE_STRIP,
    TOPO_LINE_STRIP_ADJ, TOPO_LINE_LOOP, TOPO_TRI_LIST, TOPO_RECT_LIST,
    TOPO_TRI_LIST_ADJ, TOPO_TRI_STRIP, TOPO_TRI_STRIP_ADJ, TOPO_TRI_FAN,
    TOPO_A, TOPO_QUAD_LIST, TOPO_QUAD_STRIP
  } vpg_topo_e;

  typedef struct packed {
    logic                    inst_first;
    logic                    cut;
    logic                    draw_last;
    vpg_topo_e               topo;
    logic [HANDLE_W-1:0]     handle;
    logic [3:0]              comp_sel;
    logic [1:0]              dst_off;
    logic [4*COMP_W-1:0]     comp;
  } vpg_vin_s;

  typedef struct packed {
    logic                    prim_start;
    logic                    prim_end;
    vpg_topo_e               topo;
    logic [HANDLE_W-1:0]     handle;
    logic [SEQ_W-1:0]        seq;
  } vpg_vtx_s;

  typedef struct packed {
    logic [HANDLE_W-1:0]     handle;
    logic [1:0]              dst_off;
    logic [3:0]              comp_sel;
    logic [4*COMP_W-1:0]     comp;
  } vpg_stw_s;

  typedef struct packed {
    logic [2:0] s;
    logic [2:0] r;
    logic [2:0] min;
    logic [2:0] step;
  } vpg_shape_s;

  // Skip, repeat, vertices per first object, vertices per later object
  function automatic vpg_shape_s vpg_shape(input vpg_topo_e t);
    case (t)
      TOPO_POINT_LIST:     return '{3'd1, 3'd0, 3'd1, 3'd1};
      TOPO_LINE_LIST:      return '{3'd1, 3'd1, 3'd2, 3'd2};
      TOPO_LINE_LIST_ADJ:  return '{3'd1, 3'd3, 3'd4, 3'd4};
      TOPO_LINE_STRIP:     return '{3'd2, 3'd0, 3'd2, 3'd1};
      TOPO_LINE_STRIP_ADJ: return '{3'd3, 3'd0, 3'd4, 3'd1};
      TOPO_LINE_LOOP:      return '{3'd2, 3'd0, 3'd2, 3'd1};
      TOPO_TRI_LIST:       return '{3'd1, 3'd2, 3'd3, 3'd3};
      TOPO_RECT_LIST:      return '{3'd1, 3'd2, 3'd3, 3'd3};
      TOPO_TRI_LIST_ADJ:   return '{3'd1, 3'd5, 3'd6, 3'd6};
      TOPO_TRI_STRIP_ADJ:  return '{3'd5, 3'd1, 3'd6, 3'd2};
      TOPO_QUAD_LIST:      return '{3'd1, 3'd3, 3'd4, 3'd4};
      TOPO_QUAD_STRIP:     return '{3'd3, 3'd1, 3'd4, 3'd2};
      default:             return '{3'd3, 3'd0, 3'd3, 3'd1};
    endcase
  endfunction : vpg_shape

  // Topology as seen past pipeline entry
  function automatic vpg_topo_e vpg_entry_topo(input vpg_topo_e t);
    if (t == TOPO_LINE_LOOP)
      return TOPO_LINE_STRIP;
    else if (t == TOPO_QUAD_LIST || t == TOPO_QUAD_STRIP)
      return TOPO_A;
    else
      return t;
  endfunction : vpg_entry_topo

endpackage : vpg_pkg

// File: test/vpg_prim_id_gen_props.sv
module vpg_prim_id_gen_props
  import vpg_pkg::*;
(
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                ce,
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire vpg_vin_s            in_data,
  input wire logic                st_valid,
  input wire vpg_stw_s            st_wr,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire vpg_vtx_s            out_vtx,
  input wire logic                rel_valid,
  input wire logic [HANDLE_W-1:0] rel_handle
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // Helper state
  // ----------------
  logic             hs;
  logic             take;
  logic             end_r;
  logic [SEQ_W-1:0] seq_r;
  vpg_stw_s         exp_w;
  assign hs = out_valid && out_ready;
  assign take = in_valid && in_ready && ce;
  assign exp_w = '{in_data.handle, in_data.dst_off, in_data.comp_sel, in_data.comp};
  always_ff @(posedge clk)
    if (sys_rst)
      end_r <= 1'b1;
    else if (hs)
      end_r <= out_vtx.prim_end;
  always_ff @(posedge clk)
    if (hs)
      seq_r <= out_vtx.seq;
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_vtx))
    else $error("held vertex changed");
  st_data_a: assert property (take && !in_data.cut |=> st_valid && st_wr == $past(exp_w))
    else $error("storage write wrong");
  st_cause_a: assert property (st_valid |-> $past(take && !in_data.cut))
    else $error("storage write without beat");
  cut_nost_a: assert property (take && in_data.cut |=> !st_valid)
    else $error("cut beat stored");
  topo_map_a: assert property (out_valid |->
    !(out_vtx.topo inside {TOPO_LINE_LOOP, TOPO_QUAD_LIST, TOPO_QUAD_STRIP}))
    else $error("topology not converted");
  start_end_a: assert property (hs && end_r |-> out_vtx.prim_start)
    else $error("start flag missing");
  mid_start_a: assert property (hs && !end_r |-> !out_vtx.prim_start)
    else $error("start inside primitive");
  seq_order_a: assert property (hs && !out_vtx.prim_start |-> out_vtx.seq >= seq_r)
    else $error("sequence went back");
  rel_diff_a: assert property (rel_valid && hs |-> rel_handle != out_vtx.handle)
    else $error("released handle forwarded");
  c_end: cover property (hs && out_vtx.prim_end);
  c_rel: cover property (rel_valid);
  c_stall: cover property (out_valid && !out_ready);
endmodule : vpg_prim_id_gen_props

bind vpg_prim_id_gen vpg_prim_id_gen_props u_props (.clk, .sys_rst, .ce, .in_valid,
  .in_ready, .in_data, .st_valid, .st_wr, .out_valid, .out_ready, .out_vtx,
  .rel_valid, .rel_handle);

// File: test/vpg_down_model.sv
module vpg_down_model
(
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Downstream stalls
  // ----------------
  initial out_ready = 1'b0;
  always @(posedge clk)
    out_ready <= !sys_rst && ($urandom_range(2) != 0);
endmodule : vpg_down_model

// File: test/vpg_prim_id_gen_tb.sv
module vpg_prim_id_gen_tb
  import vpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, ce = 1, in_valid = 0, cmd_valid = 0, out_ready;
  logic in_ready, st_valid, out_valid, rel_valid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rel_handle;
  logic [31:0] s_axi_wdata = 0, cmd_dword = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  vpg_vin_s    in_data = '0;
  vpg_stw_s    st_wr;
  vpg_vtx_s    out_vtx;
  vpg_vtx_s    oq[$];
  vpg_stw_s    sq[$];
  logic [7:0]  rq[$];
  int          n_fail = 0, n_checks = 0, hn = 1;
  vpg_prim_id_gen uut (.*);
  vpg_down_model u_down (.clk, .sys_rst, .out_ready);
  always #2.5 clk = ~clk;
  // ----------------
  // Checking
  // ----------------
  task close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task chk(string n, logic [141:0] e, logic [141:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task chk_vtx(vpg_vtx_s e, vpg_vtx_s g);
    chk("out", e, g);
  endtask : chk_vtx
  task chk_st(vpg_stw_s e, vpg_stw_s g);
    chk("st", e, g);
  endtask : chk_st
  task chk_rel(logic [7:0] e, logic [7:0] g);
    chk("rel", e, g);
  endtask : chk_rel
  task bad;
    n_fail++;
    close_out;
  endtask : bad
  always @(posedge clk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      chk_vtx(oq.size() ? oq.pop_front() : 'x, out_vtx);
    if (st_valid === 1'b1)
      chk_st(sq.size() ? sq.pop_front() : 'x, st_wr);
    if (rel_valid === 1'b1)
      chk_rel(rq.size() ? rq.pop_front() : 'x, rel_handle);
  end
  // ----------------
  // Drivers
  // ----------------
  task automatic wt(ref logic s);
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (s !== 1'b1 && i < 500);
    if (s !== 1'b1)
      bad;
  endtask : wt
  task bt(vpg_topo_e t, logic [2:0] fl, bit k, logic [15:0] s, logic [1:0] se);
    vpg_vin_s  b;
    vpg_topo_e et;
    et = t == TOPO_LINE_LOOP ? TOPO_LINE_STRIP : t == TOPO_QUAD_LIST ? TOPO_A : t;
    b = '{fl[2], fl[1], fl[0], t, hn[7:0], 4'($urandom), 2'($urandom),
          {$urandom, $urandom, $urandom, $urandom}};
    hn++;
    if (!fl[1])
    begin
      sq.push_back('{b.handle, b.dst_off, b.comp_sel, b.comp});
      if (k)
        oq.push_back('{se[1], se[0], et, b.handle, s});
      else
        rq.push_back(b.handle);
    end
    in_data <= b;
    in_valid <= 1'b1;
    wt(in_ready);
  endtask : bt
  task fin;
    int i;
    in_valid <= 1'b0;
    for (i = 0; i < 300 && oq.size() + rq.size() + sq.size() > 0; i++)
      @(posedge clk);
    if (i >= 300)
      bad;
  endtask : fin
  task wr(logic [7:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wt(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wt(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask : wr
  task rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wt(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask : rd
  task cmd(logic [1:0] sub, logic [2:0] ty, logic en);
    cmd_dword <= {ty, sub, 3'h0, 8'h0b, 15'h0, en};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask : cmd
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    void'($urandom(32'h994f));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(REG_CTRL, 0, RESP_OKAY);
    cmd(2'h3, 3'h3, 1'b1);
    cmd(2'h1, 3'h2, 1'b0);
    rd(REG_CTRL, 1, RESP_OKAY);
    bt(TOPO_TRI_LIST, 3'b100, 1, 0, 2'b10);
    bt(TOPO_TRI_LIST, 0, 1, 0, 0);
    bt(TOPO_TRI_LIST, 0, 1, 0, 2'b01);
    bt(TOPO_TRI_LIST, 0, 0, 0, 0);
    bt(TOPO_TRI_LIST, 3'b001, 0, 0, 0);
    fin;
    bt(TOPO_LINE_STRIP, 3'b100, 1, 0, 2'b10);
    bt(TOPO_LINE_STRIP, 0, 1, 0, 0);
    bt(TOPO_LINE_STRIP, 0, 1, 1, 2'b01);
    bt(TOPO_LINE_STRIP, 3'b010, 0, 0, 0);
    bt(TOPO_LINE_STRIP, 0, 1, 1, 2'b10);
    bt(TOPO_LINE_STRIP, 3'b001, 1, 1, 2'b01);
    fin;
    bt(TOPO_POINT_LIST, 3'b100, 1, 0, 2'b10);
    bt(TOPO_POINT_LIST, 0, 1, 1, 2'b01);
    bt(TOPO_POINT_LIST, 3'b100, 1, 0, 2'b10);
    bt(TOPO_POINT_LIST, 3'b001, 1, 1, 2'b01);
    fin;
    rd(REG_SEQ, 1, RESP_OKAY);
    ce <= 1'b0;
    cmd(2'h1, 3'h3, 1'b0);
    ce <= 1'b1;
    bt(TOPO_LINE_LOOP, 3'b100, 1, 0, 2'b10);
    bt(TOPO_LINE_LOOP, 0, 1, 0, 0);
    bt(TOPO_LINE_LOOP, 3'b001, 1, 1, 2'b01);
    fin;
    bt(TOPO_QUAD_LIST, 3'b100, 1, 0, 2'b10);
    bt(TOPO_QUAD_LIST, 0, 1, 0, 0);
    bt(TOPO_QUAD_LIST, 0, 1, 0, 0);
    bt(TOPO_QUAD_LIST, 3'b001, 1, 0, 2'b01);
    fin;
    rd(REG_VTX, 21, RESP_OKAY);
    rd(REG_OBJ, 10, RESP_OKAY);
    cmd(2'h1, 3'h3, 1'b0);
    rd(REG_CTRL, 0, RESP_OKAY);
    bt(TOPO_TRI_STRIP, 3'b100, 0, 0, 0);
    bt(TOPO_TRI_STRIP, 3'b001, 0, 0, 0);
    fin;
    rd(REG_VTX, 21, RESP_OKAY);
    rd(REG_OBJ, 10, RESP_OKAY);
    wr(REG_CTRL, 2);
    rd(REG_VTX, 0, RESP_OKAY);
    rd(8'h40, 0, RESP_SLVERR);
    rd(REG_STATUS, 0, RESP_OKAY);
    close_out;
  end
endmodule : vpg_prim_id_gen_tb
